// File: hdl/tpwm_pkg.sv
// Constants for the pulse and waveform timer block
package tpwm_pkg;
    localparam logic [5:0]  OFF_CTRL1    = 6'h00;
    localparam logic [5:0]  OFF_CTRL2    = 6'h04;
    localparam logic [5:0]  OFF_STATUS   = 6'h08;
    localparam logic [5:0]  OFF_CMP1_HI  = 6'h0C;
    localparam logic [5:0]  OFF_CMP1_LO  = 6'h10;
    localparam logic [5:0]  OFF_CMP2_HI  = 6'h14;
    localparam logic [5:0]  OFF_CMP2_LO  = 6'h18;
    localparam logic [5:0]  OFF_CAP1_HI  = 6'h1C;
    localparam logic [5:0]  OFF_CAP1_LO  = 6'h20;
    localparam logic [5:0]  OFF_CAP2_HI  = 6'h24;
    localparam logic [5:0]  OFF_CAP2_LO  = 6'h28;
    localparam logic [5:0]  OFF_COUNT    = 6'h2C;
    // Control 1 field positions
    localparam int C1_CAP_IE  = 7;
    localparam int C1_CMP_IE  = 6;
    localparam int C1_FORCE2  = 4;
    localparam int C1_FORCE1  = 3;
    localparam int C1_LEVEL2  = 2;
    localparam int C1_EDGE1   = 1;
    localparam int C1_LEVEL1  = 0;
    // Control 2 field positions
    localparam int C2_PIN1_EN = 7;
    localparam int C2_PIN2_EN = 6;
    localparam int C2_SINGLE  = 5;
    localparam int C2_CYCLIC  = 4;
    localparam int C2_DIV_HI  = 3;
    localparam int C2_DIV_LO  = 2;
    localparam int C2_EDGE2   = 1;
    localparam int C2_EXT_EDG = 0;
    // Status field positions
    localparam int ST_CAP1    = 7;
    localparam int ST_CMP1    = 6;
    localparam int ST_CAP2    = 4;
    localparam int ST_CMP2    = 3;
    // Clock divider field encodings and prescaler last counts
    localparam logic [1:0] DIV_BY4 = 2'h0;
    localparam logic [1:0] DIV_BY2 = 2'h1;
    localparam logic [1:0] DIV_BY8 = 2'h2;
    localparam logic [1:0] DIV_EXT = 2'h3;
    localparam logic [2:0] PRE_LAST4 = 3'h3;
    localparam logic [2:0] PRE_LAST2 = 3'h1;
    localparam logic [2:0] PRE_LAST8 = 3'h7;
    // Reset and load values
    localparam logic [7:0]  CTRL_RESET  = 8'h00;
    localparam logic [15:0] CMP_RESET   = 16'h8000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_LOAD  = 16'hFFFC;
    localparam logic [15:0] CAP1_LOAD   = 16'hFFFD;
endpackage : tpwm_pkg

// File: hdl/tpwm_timer.sv
// Timer with forced compare, single pulse and cyclic pulse-width modes
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps

// What this block does
// - Force bit copies level bit, no flag
// - Force bits ignored in pulse modes
// - Single pulse uses capture one, compare one
// - Trigger loads FFFC, second level, capture FFFD
// - Trigger flag may request interrupt
// - Flag clears after status read, low access
// - Compare one match ends pulse, first level
// - Timer clock divided 2/4/8 or external
// - Single pulse: no flag one, flag two works
// - Both modes selected: cyclic mode wins
// - Single pulse: capture two works, one not
// - Single pulse: compare two no pin waveform
// - Cyclic mode owns compare one and two
// - Cyclic mode compare values double buffered
// - Cyclic compare two match reloads FFFC
// - Cyclic pin one takes first level, then second
// - High byte write suspends compare until low
// - Cyclic mode never sets compare flags
// - Cyclic period end sets capture flag one
// - Cyclic mode disconnects capture pin one
// - Wait mode leaves timer running
// - Halt stops counter, resumes held count
// - Capture in halt sets flag at exit
// - External select without pin stops counter
module tpwm_timer #(
    parameter bit HAS_EXT_CLK = 1'b1
) (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        firstCapturePin,
    input  wire logic        secondCapturePin,
    input  wire logic        extClockPin,
    input  wire logic        haltMode,
    input  wire logic        cpuIrqMask,
    output logic             firstComparePin,
    output logic             firstComparePinEn,
    output logic             secondComparePin,
    output logic             secondComparePinEn,
    output logic             timerIrq
);
    typedef struct packed {
        logic [7:0]  ctrl1;
        logic [7:0]  ctrl2;
        logic        capFlag1;
        logic        capFlag2;
        logic        cmpFlag1;
        logic        cmpFlag2;
        logic [3:0]  clrArm;
        logic [15:0] count;
        logic [2:0]  pre;
        logic [15:0] cmp1;
        logic [15:0] cmp2;
        logic [15:0] cmp1Act;
        logic [15:0] cmp2Act;
        logic [1:0]  cmpInh;
        logic [1:0]  capInh;
        logic [15:0] cap1;
        logic [15:0] cap2;
        logic        pin1;
        logic        pin2;
        logic [2:0]  sync1;
        logic [2:0]  sync2;
        logic [2:0]  syncX;
        logic [1:0]  haltArm;
        logic        haltPrev;
        logic [31:0] rdata;
        logic        err;
    } tpwm_state_t;

    tpwm_state_t st_reg;
    tpwm_state_t st_next;

    // Edge seen on the settled stages; stage zero is never looked at
    function automatic logic edgeSeen(input logic [2:0] s, input logic rise);
        edgeSeen = rise ? (s[1] & ~s[2]) : (~s[1] & s[2]);
    endfunction : edgeSeen
    function automatic logic mapped(input logic [5:0] a);
        mapped = (a <= tpwm_pkg::OFF_COUNT) && (a[1:0] == 2'h0);
    endfunction : mapped

    logic [5:0] addr;
    logic       acc;
    logic       rd;
    logic       wr;

    assign addr   = paddr[5:0];
    assign acc    = psel & penable & (paddr[31:6] == 26'h000_0000);
    assign rd     = acc & ~pwrite;
    assign wr     = acc & pwrite;
    assign pready = 1'b1;
    assign prdata = st_reg.rdata;
    assign pslverr = psel & penable & st_reg.err;

    assign firstComparePin    = st_reg.pin1;
    assign firstComparePinEn  = st_reg.ctrl2[tpwm_pkg::C2_PIN1_EN];
    assign secondComparePin   = st_reg.pin2;
    assign secondComparePinEn = st_reg.ctrl2[tpwm_pkg::C2_PIN2_EN];

    // Wait mode has no input here: nothing gates the timer
    assign timerIrq = ~cpuIrqMask & (
        (st_reg.ctrl1[tpwm_pkg::C1_CAP_IE]
            & (st_reg.capFlag1 | st_reg.capFlag2)) |
        (st_reg.ctrl1[tpwm_pkg::C1_CMP_IE]
            & (st_reg.cmpFlag1 | st_reg.cmpFlag2)));
    always_comb
    begin
        logic       cyclic;
        logic       single;
        logic       tick;
        logic [2:0] preLast;
        logic       trig;
        logic       cap2Edge;
        logic       match1;
        logic       match2;
        cyclic   = st_reg.ctrl2[tpwm_pkg::C2_CYCLIC];
        single   = st_reg.ctrl2[tpwm_pkg::C2_SINGLE] & ~cyclic;
        // Pin one is the trigger in single pulse, cut off in cyclic
        trig     = edgeSeen(st_reg.sync1, st_reg.ctrl1[tpwm_pkg::C1_EDGE1]);
        cap2Edge = edgeSeen(st_reg.sync2, st_reg.ctrl2[tpwm_pkg::C2_EDGE2]);
        tick     = 1'b0;
        preLast  = tpwm_pkg::PRE_LAST4;
        match1   = 1'b0;
        match2   = 1'b0;
        st_next  = st_reg;
        st_next.sync1 = {st_reg.sync1[1:0], firstCapturePin};
        st_next.sync2 = {st_reg.sync2[1:0], secondCapturePin};
        st_next.syncX = {st_reg.syncX[1:0], extClockPin};
        st_next.haltPrev = haltMode;
        // Prescaler and timer tick
        case (st_reg.ctrl2[tpwm_pkg::C2_DIV_HI:tpwm_pkg::C2_DIV_LO])
            tpwm_pkg::DIV_BY2: preLast = tpwm_pkg::PRE_LAST2;
            tpwm_pkg::DIV_BY8: preLast = tpwm_pkg::PRE_LAST8;
            default:           preLast = tpwm_pkg::PRE_LAST4;
        endcase
        if (st_reg.ctrl2[tpwm_pkg::C2_DIV_HI:tpwm_pkg::C2_DIV_LO]
            == tpwm_pkg::DIV_EXT)
        begin
            st_next.pre = 3'h0;
            tick = HAS_EXT_CLK
                & edgeSeen(st_reg.syncX,
                           st_reg.ctrl2[tpwm_pkg::C2_EXT_EDG]);
        end
        else if (st_reg.pre == preLast)
        begin
            st_next.pre = 3'h0;
            tick = 1'b1;
        end
        else
            st_next.pre = st_reg.pre + 3'h1;
        // Counter holds in halt and restarts from the held value
        if (haltMode)
            tick = 1'b0;
        // Cyclic mode compares against the buffered copies
        if (!cyclic)
        begin
            st_next.cmp1Act = st_reg.cmp1;
            st_next.cmp2Act = st_reg.cmp2;
        end
        match1 = tick & ~st_reg.cmpInh[0] & (st_reg.count ==
            (cyclic ? st_reg.cmp1Act : st_reg.cmp1));
        match2 = tick & ~st_reg.cmpInh[1] & (st_reg.count ==
            (cyclic ? st_reg.cmp2Act : st_reg.cmp2));
        if (tick)
            st_next.count = st_reg.count + 16'h0001;
        // APB side: flag clearing sequence; sets below override
        if (psel & ~penable)
        begin
            // Kept through the access phase, where pslverr shows it
            st_next.err = ~mapped(addr);
            case (addr)
                tpwm_pkg::OFF_CTRL1:   st_next.rdata = {24'h00_0000, st_reg.ctrl1};
                tpwm_pkg::OFF_CTRL2:   st_next.rdata = {24'h00_0000, st_reg.ctrl2};
                tpwm_pkg::OFF_STATUS:
                    st_next.rdata = {24'h00_0000, st_reg.capFlag1,
                        st_reg.cmpFlag1, 1'b0, st_reg.capFlag2,
                        st_reg.cmpFlag2, 3'h0};
                tpwm_pkg::OFF_CMP1_HI: st_next.rdata = {24'h00_0000, st_reg.cmp1[15:8]};
                tpwm_pkg::OFF_CMP1_LO: st_next.rdata = {24'h00_0000, st_reg.cmp1[7:0]};
                tpwm_pkg::OFF_CMP2_HI: st_next.rdata = {24'h00_0000, st_reg.cmp2[15:8]};
                tpwm_pkg::OFF_CMP2_LO: st_next.rdata = {24'h00_0000, st_reg.cmp2[7:0]};
                tpwm_pkg::OFF_CAP1_HI: st_next.rdata = {24'h00_0000, st_reg.cap1[15:8]};
                tpwm_pkg::OFF_CAP1_LO: st_next.rdata = {24'h00_0000, st_reg.cap1[7:0]};
                tpwm_pkg::OFF_CAP2_HI: st_next.rdata = {24'h00_0000, st_reg.cap2[15:8]};
                tpwm_pkg::OFF_CAP2_LO: st_next.rdata = {24'h00_0000, st_reg.cap2[7:0]};
                tpwm_pkg::OFF_COUNT:   st_next.rdata = {16'h0000, st_reg.count};
                default:               st_next.rdata = 32'h0000_0000;
            endcase
        end
        if (rd && addr == tpwm_pkg::OFF_STATUS)
        begin
            st_next.clrArm = st_reg.clrArm | {st_reg.cmpFlag2,
                st_reg.cmpFlag1, st_reg.capFlag2, st_reg.capFlag1};
        end
        if (acc)
        begin
            case (addr)
                tpwm_pkg::OFF_CAP1_LO:
                begin
                    if (st_reg.clrArm[0])
                        st_next.capFlag1 = 1'b0;
                    st_next.clrArm[0] = 1'b0;
                    st_next.capInh[0] &= ~rd;
                end
                tpwm_pkg::OFF_CAP2_LO:
                begin
                    if (st_reg.clrArm[1])
                        st_next.capFlag2 = 1'b0;
                    st_next.clrArm[1] = 1'b0;
                    st_next.capInh[1] &= ~rd;
                end
                tpwm_pkg::OFF_CAP1_HI: st_next.capInh[0] |= rd;
                tpwm_pkg::OFF_CAP2_HI: st_next.capInh[1] |= rd;
                tpwm_pkg::OFF_CMP1_LO:
                begin
                    if (st_reg.clrArm[2])
                        st_next.cmpFlag1 = 1'b0;
                    st_next.clrArm[2] = 1'b0;
                    if (wr)
                    begin
                        st_next.cmp1[7:0] = pwdata[7:0];
                        st_next.cmpInh[0] = 1'b0;
                    end
                end
                tpwm_pkg::OFF_CMP2_LO:
                begin
                    if (st_reg.clrArm[3])
                        st_next.cmpFlag2 = 1'b0;
                    st_next.clrArm[3] = 1'b0;
                    if (wr)
                    begin
                        st_next.cmp2[7:0] = pwdata[7:0];
                        st_next.cmpInh[1] = 1'b0;
                    end
                end
                tpwm_pkg::OFF_CMP1_HI:
                    if (wr)
                    begin
                        st_next.cmp1[15:8] = pwdata[7:0];
                        st_next.cmpInh[0] = 1'b1;
                    end
                tpwm_pkg::OFF_CMP2_HI:
                    if (wr)
                    begin
                        st_next.cmp2[15:8] = pwdata[7:0];
                        st_next.cmpInh[1] = 1'b1;
                    end
                tpwm_pkg::OFF_CTRL1:
                    if (wr)
                        st_next.ctrl1 = pwdata[7:0];
                tpwm_pkg::OFF_CTRL2:
                    if (wr)
                        st_next.ctrl2 = pwdata[7:0];
                default: ;
            endcase
        end
        // Second capture works in every mode
        if (cap2Edge && haltMode)
            st_next.haltArm[1] = 1'b1;
        else if (cap2Edge && !st_reg.capInh[1])
        begin
            st_next.capFlag2 = 1'b1;
            st_next.cap2 = st_reg.count;
        end
        if (cyclic)
        begin
            // Compare flags stay untouched in cyclic mode
            if (match1)
                st_next.pin1 = st_reg.ctrl1[tpwm_pkg::C1_LEVEL1];
            if (match2)
            begin
                st_next.count    = tpwm_pkg::COUNT_LOAD;
                st_next.pre      = 3'h0;
                st_next.pin1     = st_reg.ctrl1[tpwm_pkg::C1_LEVEL2];
                st_next.capFlag1 = 1'b1;
                st_next.cmp1Act  = st_reg.cmp1;
                st_next.cmp2Act  = st_reg.cmp2;
            end
        end
        else if (single)
        begin
            // Pin stays at the first level until the next trigger
            if (match1)
                st_next.pin1 = st_reg.ctrl1[tpwm_pkg::C1_LEVEL1];
            if (match2)
                st_next.cmpFlag2 = 1'b1;
            if (trig && haltMode)
                st_next.haltArm[0] = 1'b1;
            else if (trig)
            begin
                st_next.count    = tpwm_pkg::COUNT_LOAD;
                st_next.pre      = 3'h0;
                st_next.pin1     = st_reg.ctrl1[tpwm_pkg::C1_LEVEL2];
                st_next.capFlag1 = 1'b1;
                st_next.cap1     = tpwm_pkg::CAP1_LOAD;
            end
        end
        else
        begin
            if (match1)
            begin
                st_next.cmpFlag1 = 1'b1;
                st_next.pin1 = st_reg.ctrl1[tpwm_pkg::C1_LEVEL1];
            end
            if (match2)
            begin
                st_next.cmpFlag2 = 1'b1;
                st_next.pin2 = st_reg.ctrl1[tpwm_pkg::C1_LEVEL2];
            end
            // Forcing only copies the level; no flag is touched
            if (st_reg.ctrl1[tpwm_pkg::C1_FORCE1])
                st_next.pin1 = st_reg.ctrl1[tpwm_pkg::C1_LEVEL1];
            if (st_reg.ctrl1[tpwm_pkg::C1_FORCE2])
                st_next.pin2 = st_reg.ctrl1[tpwm_pkg::C1_LEVEL2];
            if (trig && haltMode)
                st_next.haltArm[0] = 1'b1;
            else if (trig && !st_reg.capInh[0])
            begin
                st_next.capFlag1 = 1'b1;
                st_next.cap1 = st_reg.count;
            end
        end
        // Leaving halt without reset: armed captures take the held count
        if (st_reg.haltPrev & ~haltMode)
        begin
            st_next.haltArm = 2'h0;
            if (st_reg.haltArm[0])
            begin
                st_next.capFlag1 = 1'b1;
                st_next.cap1 = st_reg.count;
            end
            if (st_reg.haltArm[1])
            begin
                st_next.capFlag2 = 1'b1;
                st_next.cap2 = st_reg.count;
            end
        end
    end
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            st_reg          <= '0;
            st_reg.ctrl1    <= tpwm_pkg::CTRL_RESET;
            st_reg.ctrl2    <= tpwm_pkg::CTRL_RESET;
            st_reg.count    <= tpwm_pkg::COUNT_RESET;
            st_reg.cmp1     <= tpwm_pkg::CMP_RESET;
            st_reg.cmp2     <= tpwm_pkg::CMP_RESET;
            st_reg.cmp1Act  <= tpwm_pkg::CMP_RESET;
            st_reg.cmp2Act  <= tpwm_pkg::CMP_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end
endmodule : tpwm_timer

// File: test/tpwm_timer_assertions.sv
// Port-level checks for the pulse and waveform timer
`timescale 1ns/1ps
module tpwm_timer_assertions (
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        firstCapturePin,
    input wire logic        secondCapturePin,
    input wire logic        extClockPin,
    input wire logic        haltMode,
    input wire logic        cpuIrqMask,
    input wire logic        firstComparePin,
    input wire logic        firstComparePinEn,
    input wire logic        secondComparePin,
    input wire logic        secondComparePinEn,
    input wire logic        timerIrq
);
    logic [7:0] ctl1_reg;
    logic [7:0] ctl2_reg;
    logic       apbWr;
    logic       plainMode;
    // Shadow the control writes so the mode is known from the ports alone
    assign apbWr = psel && penable && pwrite && pready;
    assign plainMode = !ctl2_reg[tpwm_pkg::C2_SINGLE]
                    && !ctl2_reg[tpwm_pkg::C2_CYCLIC];
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            ctl1_reg <= tpwm_pkg::CTRL_RESET;
            ctl2_reg <= tpwm_pkg::CTRL_RESET;
        end
        else if (apbWr && paddr[5:0] == tpwm_pkg::OFF_CTRL1)
            ctl1_reg <= pwdata[7:0];
        else if (apbWr && paddr[5:0] == tpwm_pkg::OFF_CTRL2)
            ctl2_reg <= pwdata[7:0];
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    a_ready_always: assert property (pready)
        else $error("pready low");
    a_err_in_access: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
    a_err_unmapped: assert property (psel && penable &&
        (paddr[5:0] > tpwm_pkg::OFF_COUNT || paddr[1:0] != 2'h0) |-> pslverr)
        else $error("unmapped access not refused");
    a_irq_masked: assert property (cpuIrqMask |-> !timerIrq)
        else $error("interrupt while masked");
    a_irq_needs_en: assert property (!ctl1_reg[7] && !ctl1_reg[6]
        |-> !timerIrq)
        else $error("interrupt with both enables off");
    a_force_one: assert property (plainMode && ctl1_reg[3]
        && ctl2_reg[7] && $stable(ctl1_reg) && $stable(ctl2_reg)
        |-> firstComparePin == ctl1_reg[0])
        else $error("forced level missing on first pin");
    a_force_two: assert property (plainMode && ctl1_reg[4]
        && ctl2_reg[6] && $stable(ctl1_reg) && $stable(ctl2_reg)
        |-> secondComparePin == ctl1_reg[2])
        else $error("forced level missing on second pin");
    a_pin_enables: assert property ($stable(ctl2_reg) |->
        {firstComparePinEn, secondComparePinEn} == ctl2_reg[7:6])
        else $error("pin enables differ from control");
    a_halt_frozen: assert property ((haltMode && !psel)[*3]
        |-> $stable({firstComparePin, secondComparePin}))
        else $error("compare pins moved in halt");
endmodule : tpwm_timer_assertions

// File: test/tpwm_pin_model.sv
// Trigger source and compare pin watcher beside the timer
`timescale 1ns/1ps
module tpwm_pin_model (
    input  wire logic clock,
    input  wire logic firstComparePin,
    output logic      firstCapturePin = 1'b0,
    output logic      secondCapturePin = 1'b0,
    output logic      extClockPin = 1'b0
);
    logic extRun = 1'b0;
    logic lastPin = 1'b0;
    int   extCnt = 0;
    int   sinceRise = 0;
    int   lastPeriod = 0;
    // High long enough to pass the two-flop synchroniser
    task automatic pulsePin(input int which);
        @(posedge clock);
        if (which == 1)
            firstCapturePin <= 1'b1;
        else
            secondCapturePin <= 1'b1;
        repeat (6) @(posedge clock);
        firstCapturePin <= 1'b0;
        secondCapturePin <= 1'b0;
    endtask : pulsePin
    // Ten-cycle period keeps active edges well apart; still outside use
    always @(posedge clock)
    begin
        if (extRun)
            extCnt <= (extCnt == 4) ? 0 : extCnt + 1;
        if (extRun && extCnt == 4)
            extClockPin <= !extClockPin;
        sinceRise <= sinceRise + 1;
        if (firstComparePin && !lastPin)
        begin
            lastPeriod <= sinceRise + 1;
            sinceRise <= 0;
        end
        lastPin <= firstComparePin;
    end
endmodule : tpwm_pin_model

// File: test/tb_top.sv
// Directed bench for the pulse and waveform timer
`timescale 1ns/1ps
module tb_top;
    logic        clock;
    logic        rstn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        firstCapturePin;
    logic        secondCapturePin;
    logic        extClockPin;
    logic        haltMode;
    logic        cpuIrqMask;
    logic        firstComparePin;
    logic        firstComparePinEn;
    logic        secondComparePin;
    logic        secondComparePinEn;
    logic        timerIrq;
    logic [31:0] q;
    logic [31:0] c0;
    logic        err;
    int          miscompares = 0;
    int          checked = 0;
    int          divN[4] = '{2, 4, 8, 10};
    logic [1:0]  divCode[4] = '{tpwm_pkg::DIV_BY2, tpwm_pkg::DIV_BY4,
                                tpwm_pkg::DIV_BY8, tpwm_pkg::DIV_EXT};

    tpwm_timer tpwm_timer_inst (.*);
    tpwm_pin_model tpwm_pin_model_inst (.clock(clock),
        .firstComparePin(firstComparePin), .firstCapturePin(firstCapturePin),
        .secondCapturePin(secondCapturePin), .extClockPin(extClockPin));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [5:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {26'h0, a};
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
            @(posedge clock);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // High byte first: the compare stays off until the low byte lands
    task automatic wr16(input logic [5:0] hi, input logic [15:0] v);
        apb(1'b1, hi, {24'h0, v[15:8]});
        apb(1'b1, hi + 6'h04, {24'h0, v[7:0]});
    endtask : wr16
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask : settle
    task automatic inRange(input logic [31:0] v, input int lo, input int hi);
        chk({31'h0, v >= lo && v <= hi}, 32'h0000_0001);
    endtask : inRange
    task automatic pinWait(input logic v);
        int n;
        n = 0;
        while (firstComparePin !== v && n < 400)
        begin
            @(posedge clock);
            n++;
        end
        chk({31'h0, firstComparePin}, {31'h0, v});
    endtask : pinWait
    function automatic logic [31:0] outs();
        return {29'h0, timerIrq, secondComparePin, firstComparePin};
    endfunction : outs
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial
    begin
        repeat (20000) @(posedge clock);
        miscompares++;
        print_verdict();
    end
    initial
    begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0000_0000;
        pwdata = 32'h0000_0000;
        haltMode = 1'b0;
        cpuIrqMask = 1'b0;
        repeat (20) @(posedge clock);
        rstn <= 1'b1;
        apb(1'b0, tpwm_pkg::OFF_CMP1_HI, 32'h0);
        chk(q, 32'h0000_0080);
        apb(1'b0, 6'h30, 32'h0);
        chk({q[30:0], err}, 32'h0000_0001);
        apb(1'b1, tpwm_pkg::OFF_CTRL2, 32'h0000_00C0);
        apb(1'b1, tpwm_pkg::OFF_CTRL1, 32'h0000_0059);
        settle(2);
        chk(outs(), 32'h0000_0001);
        apb(1'b1, tpwm_pkg::OFF_CTRL1, 32'h0000_005C);
        settle(2);
        chk(outs(), 32'h0000_0002);
        // Single pulse with a forced low level that must be ignored
        wr16(tpwm_pkg::OFF_CMP1_HI, 16'h0030);
        apb(1'b1, tpwm_pkg::OFF_CTRL1, 32'h0000_008E);
        apb(1'b1, tpwm_pkg::OFF_CTRL2, 32'h0000_00A6);
        tpwm_pin_model_inst.pulsePin(1);
        settle(0);
        chk(outs() & 32'h0000_0005, 32'h0000_0005);
        @(posedge clock) cpuIrqMask <= 1'b1;
        settle(0);
        chk({31'h0, timerIrq}, 32'h0);
        @(posedge clock) cpuIrqMask <= 1'b0;
        tpwm_pin_model_inst.pulsePin(2);
        apb(1'b0, tpwm_pkg::OFF_STATUS, 32'h0);
        chk(q & 32'h0000_00D8, 32'h0000_0090);
        apb(1'b0, tpwm_pkg::OFF_CAP1_HI, 32'h0);
        c0 = q;
        apb(1'b0, tpwm_pkg::OFF_CAP1_LO, 32'h0);
        chk({c0[23:0], q[7:0]}, 32'h0000_FFFD);
        apb(1'b0, tpwm_pkg::OFF_CAP2_LO, 32'h0);
        apb(1'b0, tpwm_pkg::OFF_STATUS, 32'h0);
        chk({q[31:8], q[7] | q[4], 6'h0, timerIrq}, 32'h0);
        pinWait(1'b0);
        apb(1'b0, tpwm_pkg::OFF_STATUS, 32'h0);
        chk(q & 32'h0000_0040, 32'h0);
        settle(100);
        chk({31'h0, firstComparePin}, 32'h0);
        // Both mode bits set: cyclic output, period ends at compare two
        wr16(tpwm_pkg::OFF_CMP1_HI, 16'h0004);
        wr16(tpwm_pkg::OFF_CMP2_HI, 16'h0010);
        apb(1'b1, tpwm_pkg::OFF_CTRL1, 32'h0000_00C1);
        tpwm_pin_model_inst.pulsePin(1);
        apb(1'b1, tpwm_pkg::OFF_CTRL2, 32'h0000_00B4);
        settle(200);
        inRange(tpwm_pin_model_inst.lastPeriod, 40, 42);
        apb(1'b0, tpwm_pkg::OFF_STATUS, 32'h0);
        chk(q & 32'h0000_00C8, 32'h0000_0080);
        chk({31'h0, timerIrq}, 32'h0000_0001);
        wr16(tpwm_pkg::OFF_CMP2_HI, 16'h0020);
        settle(300);
        inRange(tpwm_pin_model_inst.lastPeriod, 72, 74);
        apb(1'b1, tpwm_pkg::OFF_CTRL1, 32'h0);
        @(posedge clock) tpwm_pin_model_inst.extRun <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, tpwm_pkg::OFF_CTRL2, {28'h0, divCode[i], 2'b01});
            apb(1'b0, tpwm_pkg::OFF_COUNT, 32'h0);
            c0 = q;
            repeat (80) @(posedge clock);
            apb(1'b0, tpwm_pkg::OFF_COUNT, 32'h0);
            inRange({16'h0, q[15:0] - c0[15:0]}, 82 / divN[i] - 1,
                    82 / divN[i] + 1);
        end
        // Capture edge during halt must wait for the wake-up
        apb(1'b1, tpwm_pkg::OFF_CTRL2, 32'h0000_0006);
        @(posedge clock) haltMode <= 1'b1;
        apb(1'b0, tpwm_pkg::OFF_COUNT, 32'h0);
        c0 = q;
        tpwm_pin_model_inst.pulsePin(2);
        apb(1'b0, tpwm_pkg::OFF_STATUS, 32'h0);
        chk(q & 32'h0000_0010, 32'h0);
        apb(1'b0, tpwm_pkg::OFF_COUNT, 32'h0);
        chk(q, c0);
        @(posedge clock) haltMode <= 1'b0;
        settle(4);
        apb(1'b0, tpwm_pkg::OFF_STATUS, 32'h0);
        chk(q & 32'h0000_0010, 32'h0000_0010);
        apb(1'b0, tpwm_pkg::OFF_CAP2_HI, 32'h0);
        c0[31:16] = {q[7:0], 8'h00};
        apb(1'b0, tpwm_pkg::OFF_CAP2_LO, 32'h0);
        inRange({16'h0, c0[31:16] + q[7:0] - c0[15:0]}, 0, 3);
        print_verdict();
    end
endmodule : tb_top

bind tpwm_timer tpwm_timer_assertions tpwm_timer_assertions_inst (.*);
